// [dcf_consts.svh]
// Purpose: constants of the DMA channel event flag block
// Assumes: 32-bit AHB-Lite register window, eight channels
// Notes: offsets are byte addresses within the block
`ifndef DCF_CONSTS_SVH
`define DCF_CONSTS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define DCF_CH_STRIDE 8'h10
`define DCF_OFF_INT_CTRL 8'h00
`define DCF_OFF_ABORT_SEL 8'h04
`define DCF_OFF_IFS_ONE 8'h80
`define DCF_OFF_IEC_ONE 8'h84
`define DCF_OFF_IPC_NINE 8'h88
`define DCF_OFF_IPC_TEN 8'h8C

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define DCF_BIT_DEST_DONE 5
`define DCF_BIT_DEST_HALF 4
`define DCF_BIT_BLOCK 3
`define DCF_BIT_CELL 2
`define DCF_BIT_ABORT 1
`define DCF_BIT_ADDR_ERR 0
`define DCF_EN_LSB 16
`define DCF_ABORT_EN_BIT 8
`define DCF_IFS_LSB 16
`define DCF_PRIO_LSB 2
`define DCF_SUB_LSB 0
`define DCF_IPC_SLOT 8

// ----------------------------------------------------------------
// interrupt identities and reset values
// ----------------------------------------------------------------
`define DCF_IRQ_BASE 6'h30
`define DCF_VEC_BASE 6'h24
`define DCF_RST_WORD 32'h0000_0000
`define DCF_RST_FLAGS 6'h00

`endif

// [dcf_pkg.sv]
// Purpose: types of the DMA channel event flag block
// Assumes: used with dcf_consts.svh
// Notes: bus states are one-hot
package dcf_pkg;
  typedef enum logic [2:0] {
    DCF_BUS_IDLE = 3'b001,
    DCF_BUS_WAIT = 3'b010,
    DCF_BUS_DONE = 3'b100
  } dcf_bus_type;
  typedef logic [7:0][15:0] dcf_size_type;
  typedef logic [5:0] dcf_flags_type;
endpackage

// [dcf_event_flags.sv]
// Purpose: per-channel event flags and interrupt link of an eight channel DMA engine
// Assumes: engine counters and request lines are on hclk; registers over AHB-Lite
// Notes: every transfer takes one wait state so a read never sees stale data
`include "dcf_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module dcf_event_flags (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire dcf_pkg::dcf_size_type destination_pointer,
  input wire dcf_pkg::dcf_size_type destination_size,
  input wire dcf_pkg::dcf_size_type source_size,
  input wire dcf_pkg::dcf_size_type cell_size,
  input wire dcf_pkg::dcf_size_type block_count,
  input wire dcf_pkg::dcf_size_type cell_count,
  input wire logic [7:0] pattern_match,
  input wire logic [7:0] src_addr_invalid,
  input wire logic [7:0] dst_addr_invalid,
  input wire logic [63:0] irq_request,
  output logic [7:0] chan_abort,
  output logic irq,
  output logic irq_valid,
  output logic [5:0] irq_number,
  output logic [5:0] irq_vector
);
  import dcf_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  dcf_bus_type bus_r;
  logic [7:0] addr_r;
  logic write_r;
  dcf_flags_type flag_r [8];
  dcf_flags_type en_r [8];
  logic [5:0] abort_sel_r [8];
  logic [7:0] abort_en_r;
  logic [7:0] ifs_r;
  logic [7:0] iec_r;
  logic [2:0] prio_r [8];
  logic [1:0] sub_r [8];
  logic [7:0] dd_prev_r;
  logic [7:0] dh_prev_r;
  logic [7:0] bc_prev_r;
  logic [7:0] cc_prev_r;
  logic [63:0] req_prev_r;
  dcf_flags_type ev [8];
  dcf_flags_type clr [8];
  logic [7:0] abort_hit;
  logic [7:0] ch_pending;
  logic wr_now;

  // which channel a per-channel offset points at, or 8 for shared registers
  function automatic logic [3:0] dcf_chan(input logic [7:0] a);
    dcf_chan = a[7] ? 4'h8 : {1'b0, a[6:4]};
  endfunction

  // 3+2 bit priority slot of one channel in a priority word
  function automatic logic [4:0] dcf_slot(input logic [31:0] w, input logic [1:0] s);
    dcf_slot = w[{s, 3'b000} +: 5];
  endfunction

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  assign wr_now = (bus_r == DCF_BUS_WAIT) && write_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_r <= DCF_BUS_IDLE;
      addr_r <= 8'h00;
      write_r <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      case (bus_r)
        DCF_BUS_IDLE, DCF_BUS_DONE: begin
          if (hsel && hready && htrans[1]) begin
            bus_r <= DCF_BUS_WAIT;
            addr_r <= haddr[7:0];
            write_r <= hwrite;
            hreadyout <= 1'b0;
          end else begin
            bus_r <= DCF_BUS_IDLE;
            hreadyout <= 1'b1;
          end
        end
        DCF_BUS_WAIT: begin
          bus_r <= DCF_BUS_DONE;
          hreadyout <= 1'b1;
        end
        default: begin
          bus_r <= DCF_BUS_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // read data is built in the wait cycle, after any earlier write has landed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `DCF_RST_WORD;
    end else if (bus_r == DCF_BUS_WAIT && !write_r) begin
      hrdata <= `DCF_RST_WORD;
      if (dcf_chan(addr_r) != 4'h8) begin
        if (addr_r[3:0] == `DCF_OFF_INT_CTRL) begin
          hrdata <= {10'h000, en_r[addr_r[6:4]], 10'h000, flag_r[addr_r[6:4]]};
        end else if (addr_r[3:0] == `DCF_OFF_ABORT_SEL) begin
          hrdata <= {23'h00_0000, abort_en_r[addr_r[6:4]], 2'b00, abort_sel_r[addr_r[6:4]]};
        end
      end else begin
        case (addr_r)
          `DCF_OFF_IFS_ONE: hrdata <= {8'h00, ifs_r, 16'h0000};
          `DCF_OFF_IEC_ONE: hrdata <= {8'h00, iec_r, 16'h0000};
          `DCF_OFF_IPC_NINE: begin
            for (int k = 0; k < 4; k++) begin
              hrdata[k*`DCF_IPC_SLOT +: 5] <= {prio_r[k], sub_r[k]};
            end
          end
          `DCF_OFF_IPC_TEN: begin
            for (int k = 0; k < 4; k++) begin
              hrdata[k*`DCF_IPC_SLOT +: 5] <= {prio_r[k+4], sub_r[k+4]};
            end
          end
          default: hrdata <= `DCF_RST_WORD;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // per-channel events and flags
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 8; g++) begin : g_ch
    logic [15:0] big_size;
    logic dd_now;
    logic dh_now;
    logic bc_now;
    logic cc_now;
    logic ctl_hit;
    logic sel_hit;

    assign big_size = (source_size[g] > destination_size[g]) ? source_size[g] : destination_size[g];
    assign dd_now = destination_pointer[g] == destination_size[g];
    assign dh_now = destination_pointer[g] == {1'b0, destination_size[g][15:1]};
    assign bc_now = block_count[g] == big_size;
    assign cc_now = (cell_count[g] == cell_size[g]) && (cell_size[g] != 16'h0000);
    assign abort_hit[g] = abort_en_r[g] && irq_request[abort_sel_r[g]] && !req_prev_r[abort_sel_r[g]];
    assign ctl_hit = wr_now && (addr_r == 8'(g * `DCF_CH_STRIDE + `DCF_OFF_INT_CTRL));
    assign sel_hit = wr_now && (addr_r == 8'(g * `DCF_CH_STRIDE + `DCF_OFF_ABORT_SEL));

    // pointer, count and abort events fire on the cycle the condition becomes true; pattern match and address errors fire while they hold
    assign ev[g][`DCF_BIT_DEST_DONE] = dd_now && !dd_prev_r[g];
    assign ev[g][`DCF_BIT_DEST_HALF] = dh_now && !dh_prev_r[g];
    assign ev[g][`DCF_BIT_BLOCK] = (bc_now && !bc_prev_r[g]) || pattern_match[g];
    assign ev[g][`DCF_BIT_CELL] = cc_now && !cc_prev_r[g];
    assign ev[g][`DCF_BIT_ABORT] = abort_hit[g];
    assign ev[g][`DCF_BIT_ADDR_ERR] = src_addr_invalid[g] || dst_addr_invalid[g];
    assign clr[g] = ctl_hit ? hwdata[5:0] : `DCF_RST_FLAGS;
    assign ch_pending[g] = |(flag_r[g] & en_r[g]);

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        dd_prev_r[g] <= 1'b0;
        dh_prev_r[g] <= 1'b0;
        bc_prev_r[g] <= 1'b0;
        cc_prev_r[g] <= 1'b0;
      end else begin
        dd_prev_r[g] <= dd_now;
        dh_prev_r[g] <= dh_now;
        bc_prev_r[g] <= bc_now;
        cc_prev_r[g] <= cc_now;
      end
    end

    // write-one-to-clear; a same-cycle event wins over the clear
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        flag_r[g] <= `DCF_RST_FLAGS;
      end else begin
        flag_r[g] <= (flag_r[g] & ~clr[g]) | ev[g];
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        en_r[g] <= `DCF_RST_FLAGS;
        abort_sel_r[g] <= 6'h00;
        abort_en_r[g] <= 1'b0;
      end else begin
        if (ctl_hit) begin
          en_r[g] <= hwdata[`DCF_EN_LSB +: 6];
        end
        if (sel_hit) begin
          abort_sel_r[g] <= hwdata[5:0];
          abort_en_r[g] <= hwdata[`DCF_ABORT_EN_BIT];
        end
      end
    end

    // abort strobe to the transfer engine
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        chan_abort[g] <= 1'b0;
      end else begin
        chan_abort[g] <= abort_hit[g];
      end
    end

    a_dest_done_set: assert property (@(posedge hclk) disable iff (!hresetn)
      (dd_now && !dd_prev_r[g]) |=> flag_r[g][`DCF_BIT_DEST_DONE])
      else $error("destination done flag not set");
    a_dest_half_set: assert property (@(posedge hclk) disable iff (!hresetn)
      (dh_now && !dh_prev_r[g]) |=> flag_r[g][`DCF_BIT_DEST_HALF])
      else $error("destination half flag not set");
    a_block_done_set: assert property (@(posedge hclk) disable iff (!hresetn)
      (pattern_match[g] || (bc_now && !bc_prev_r[g])) |=> flag_r[g][`DCF_BIT_BLOCK])
      else $error("block complete flag not set");
    a_cell_done_set: assert property (@(posedge hclk) disable iff (!hresetn)
      (cc_now && !cc_prev_r[g]) |=> flag_r[g][`DCF_BIT_CELL])
      else $error("cell complete flag not set");
    a_abort_pulse_flag: assert property (@(posedge hclk) disable iff (!hresetn)
      abort_hit[g] |=> chan_abort[g] && flag_r[g][`DCF_BIT_ABORT])
      else $error("abort not issued with its flag");
    a_addr_err_set: assert property (@(posedge hclk) disable iff (!hresetn)
      (src_addr_invalid[g] || dst_addr_invalid[g]) |=> flag_r[g][`DCF_BIT_ADDR_ERR])
      else $error("address error flag not set");
    a_flag_only_cleared: assert property (@(posedge hclk) disable iff (!hresetn)
      $fell(flag_r[g][`DCF_BIT_ADDR_ERR]) |-> $past(clr[g][`DCF_BIT_ADDR_ERR]))
      else $error("flag dropped without a software clear");
    a_chan_to_ifs: assert property (@(posedge hclk) disable iff (!hresetn)
      ch_pending[g] |=> ifs_r[g])
      else $error("channel pending did not reach its flag bit");
  end

  // ----------------------------------------------------------------
  // interrupt controller side: flag, enable and priority registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_prev_r <= 64'h0000_0000_0000_0000;
    end else begin
      req_prev_r <= irq_request;
    end
  end

  // channel g lands on bit 16+g; a pending channel wins over a clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ifs_r <= 8'h00;
    end else begin
      if (wr_now && addr_r == `DCF_OFF_IFS_ONE) begin
        ifs_r <= (ifs_r & ~hwdata[`DCF_IFS_LSB +: 8]) | ch_pending;
      end else begin
        ifs_r <= ifs_r | ch_pending;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      iec_r <= 8'h00;
      for (int k = 0; k < 8; k++) begin
        prio_r[k] <= 3'h0;
        sub_r[k] <= 2'h0;
      end
    end else if (wr_now) begin
      if (addr_r == `DCF_OFF_IEC_ONE) begin
        iec_r <= hwdata[`DCF_IFS_LSB +: 8];
      end
      for (int k = 0; k < 4; k++) begin
        if (addr_r == `DCF_OFF_IPC_NINE) begin
          {prio_r[k], sub_r[k]} <= dcf_slot(hwdata, 2'(k));
        end
        if (addr_r == `DCF_OFF_IPC_TEN) begin
          {prio_r[k+4], sub_r[k+4]} <= dcf_slot(hwdata, 2'(k));
        end
      end
    end
  end

  // highest priority, then subpriority, then lowest channel wins
  logic [2:0] win_ch;
  logic win_any;
  always_comb begin
    win_ch = 3'h0;
    win_any = 1'b0;
    for (int k = 0; k < 8; k++) begin
      if (ifs_r[k] && iec_r[k]) begin
        if (!win_any || {prio_r[k], sub_r[k]} > {prio_r[win_ch], sub_r[win_ch]}) begin
          win_ch = 3'(k);
          win_any = 1'b1;
        end
      end
    end
  end

  // each channel owns its vector; no sharing between channels
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
      irq_valid <= 1'b0;
      irq_number <= 6'h00;
      irq_vector <= 6'h00;
    end else begin
      irq <= win_any;
      irq_valid <= win_any;
      irq_number <= `DCF_IRQ_BASE + {3'b000, win_ch};
      irq_vector <= `DCF_VEC_BASE + {3'b000, win_ch};
    end
  end

  sequence s_addr_phase;
    hsel && hready && htrans[1] && hreadyout;
  endsequence
  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  a_bus_one_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    s_addr_phase |=> s_one_wait)
    else $error("bus transfer did not take exactly one wait state");
  a_vector_map: assert property (@(posedge hclk) disable iff (!hresetn)
    irq_valid |-> (irq_number - irq_vector == 6'h0C) && irq_number >= 6'h30 && irq_number <= 6'h37)
    else $error("request number and vector out of step");
  a_irq_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    (|(ifs_r & iec_r)) |=> irq)
    else $error("unmasked flag did not raise the interrupt");
  a_prio_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_now && addr_r == `DCF_OFF_IPC_NINE) |=>
      prio_r[1] == $past(hwdata[12:10]) && sub_r[1] == $past(hwdata[9:8]))
    else $error("channel one priority field misplaced");

endmodule
`default_nettype wire

// [dcf_irq_ctrl_model.sv]
// Purpose: model of the system interrupt controller facing the DMA flag block
// Assumes: request lines and vector fetch run on hclk
// Notes: request lines are levels; the bench raises and drops them by task
`timescale 1ns/1ps
`default_nettype none

module dcf_irq_ctrl_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic irq_valid,
  input wire logic [5:0] irq_vector,
  output logic [63:0] irq_request,
  output logic [5:0] taken_vector
);
  initial irq_request = 64'h0000_0000_0000_0000;

  // lines change just after an edge so the block sees a clean rise
  task automatic set_line(input int n, input logic v);
    @(posedge hclk);
    irq_request[n] <= v;
  endtask

  // vector is fetched only while the request is flagged valid
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      taken_vector <= 6'h00;
    end else if (irq_valid) begin
      taken_vector <= irq_vector;
    end
  end
endmodule

`default_nettype wire

// [tb_top.sv]
// Purpose: self-checking bench of the DMA channel event flag block
// Assumes: one AHB-Lite slave, hready tied to hreadyout
// Notes: destination sizes start at 16'hFFFF and cell sizes at zero so no event fires out of reset
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_fail++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end

module tb_top;
  import dcf_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, irq_valid;
  wire logic hready;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  dcf_size_type dptr, dsz, ssz, csz, bcnt, ccnt;
  logic [7:0] pm, sinv, dinv, chan_abort;
  logic [63:0] irq_request;
  logic [5:0] irq_number, irq_vector, taken_vector;
  int n_fail = 0;
  int n_tests = 0;
  int np;

  assign hready = hreadyout;

  dcf_event_flags dcf_event_flags_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .destination_pointer(dptr), .destination_size(dsz),
    .source_size(ssz), .cell_size(csz), .block_count(bcnt), .cell_count(ccnt), .pattern_match(pm),
    .src_addr_invalid(sinv), .dst_addr_invalid(dinv), .irq_request(irq_request), .chan_abort(chan_abort),
    .irq(irq), .irq_valid(irq_valid), .irq_number(irq_number), .irq_vector(irq_vector));

  dcf_irq_ctrl_model partner_inst (.hclk(hclk), .hresetn(hresetn), .irq_valid(irq_valid),
    .irq_vector(irq_vector), .irq_request(irq_request), .taken_vector(taken_vector));

  // ----------------------------------------------------------------
  // bus and stimulus tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 16);
    if (k >= 16) begin
      n_fail++;
      $display("ERROR hready expected 1 seen %b", hready);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    `CHK(nm, e, q)
  endtask

  // odd channels report a bad destination, even ones a bad source
  task automatic pulse_err(input int c);
    if (c % 2 == 1) dinv[c] <= 1'b1;
    else sinv[c] <= 1'b1;
    @(posedge hclk);
    sinv <= 8'h00;
    dinv <= 8'h00;
    @(posedge hclk);
  endtask

  task automatic count_abort(output int n);
    n = 0;
    repeat (5) begin
      @(posedge hclk);
      if (chan_abort === 8'h10) n++;
    end
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    report_and_stop();
  end

  initial begin
    {hsel, hwrite, haddr, hwdata, htrans, hresetn} = '0;
    hsize = 3'b010;
    {dptr, ssz, csz, bcnt, ccnt, pm, sinv, dinv} = '0;
    dsz = {8{16'hFFFF}};
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    tick(2);
    `CHK("irq after reset", 1'b0, irq)
    rdchk("ctrl reset", 8'h00, 32'h0000_0000);
    rdchk("flag reg reset", 8'h80, 32'h0000_0000);
    wr(8'hF0, 32'hFFFF_FFFF);
    rdchk("unmapped", 8'hF0, 32'h0000_0000);
    `CHK("hresp", 1'b0, hresp)
    dsz[2] <= 16'h0010;
    tick(2);
    dptr[2] <= 16'h0008;
    tick(2);
    rdchk("half flag", 8'h20, 32'h0000_0010);
    dptr[2] <= 16'h0010;
    tick(2);
    rdchk("done flag", 8'h20, 32'h0000_0030);
    wr(8'h20, 32'h0000_0030);
    rdchk("done cleared", 8'h20, 32'h0000_0000);
    csz[1] <= 16'h0004;
    ccnt[1] <= 16'h0004;
    tick(2);
    rdchk("cell flag", 8'h10, 32'h0000_0004);
    wr(8'h10, 32'h0000_0004);
    ccnt[1] <= 16'h0000;
    tick(2);
    ccnt[1] <= 16'h0004;
    tick(2);
    rdchk("cell again", 8'h10, 32'h0000_0004);
    wr(8'h10, 32'h0000_0004);
    ssz[5] <= 16'h0020;
    dsz[5] <= 16'h0010;
    tick(2);
    bcnt[5] <= 16'h0010;
    tick(2);
    rdchk("block early", 8'h50, 32'h0000_0000);
    bcnt[5] <= 16'h0020;
    tick(2);
    rdchk("block flag", 8'h50, 32'h0000_0008);
    wr(8'h50, 32'h0000_0008);
    pm[6] <= 1'b1;
    tick(1);
    pm[6] <= 1'b0;
    tick(2);
    rdchk("match flag", 8'h60, 32'h0000_0008);
    wr(8'h60, 32'h0000_0008);
    pulse_err(3);
    tick(20);
    rdchk("error sticky", 8'h30, 32'h0000_0001);
    wr(8'h30, 32'h0000_0001);
    wr(8'h44, 32'h0000_010A);
    partner_inst.set_line(10, 1'b1);
    count_abort(np);
    `CHK("abort pulses", 1, np)
    rdchk("abort flag", 8'h40, 32'h0000_0002);
    wr(8'h40, 32'h0000_0002);
    partner_inst.set_line(10, 1'b0);
    wr(8'h44, 32'h0000_000A);
    partner_inst.set_line(10, 1'b1);
    count_abort(np);
    `CHK("abort disabled", 0, np)
    rdchk("no abort flag", 8'h40, 32'h0000_0000);
    wr(8'h80, 32'h00FF_0000);
    for (int c = 0; c < 8; c++) begin
      wr(8'(c * 16), 32'h0001_0000);
      pulse_err(c);
      tick(5);
      `CHK("masked irq", 1'b0, irq)
      wr(8'h84, 32'(1) << (16 + c));
      tick(3);
      `CHK("irq", 1'b1, irq)
      `CHK("irq valid", 1'b1, irq_valid)
      `CHK("irq number", 6'(48 + c), irq_number)
      `CHK("irq vector", 6'(36 + c), irq_vector)
      `CHK("taken vector", 6'(36 + c), taken_vector)
      rdchk("flag reg", 8'h80, 32'(1) << (16 + c));
      wr(8'(c * 16), 32'h0000_0001);
      wr(8'h80, 32'h00FF_0000);
      tick(3);
      `CHK("irq cleared", 1'b0, irq)
    end
    wr(8'h88, 32'h0000_1600);
    rdchk("prio reg", 8'h88, 32'h0000_1600);
    wr(8'h8C, 32'h1C00_0000);
    rdchk("prio reg ten", 8'h8C, 32'h1C00_0000);
    wr(8'h00, 32'h0001_0000);
    wr(8'h10, 32'h0001_0000);
    wr(8'h84, 32'h0003_0000);
    pulse_err(0);
    pulse_err(1);
    tick(5);
    `CHK("prio winner", 6'h31, irq_number)
    wr(8'h88, 32'h0000_0000);
    tick(3);
    `CHK("tie winner", 6'h30, irq_number)
    report_and_stop();
  end
endmodule

`default_nettype wire
